// ===== gpio_pad_model.sv
`timescale 1ns/100ps
`default_nettype none
module gpio_pad_model #(
  parameter int WIDTH = 4
) (
  input wire logic clk_i, // clock
  input wire logic [WIDTH-1:0] pad_i, // pad value
  input wire logic [WIDTH-1:0] oe_n_i, // low drives
  input wire logic [WIDTH-1:0] pullup_i, // pull-up on
  input wire logic [WIDTH-1:0] ext_en_i, // outside drive on
  input wire logic [WIDTH-1:0] ext_i, // outside value
  output logic [WIDTH-1:0] level_o // pin level
);
  // Undriven pins without pull-up toggle so no stale level survives
  logic [WIDTH-1:0] float_r = '0;
  always @(posedge clk_i) begin
    float_r <= ~float_r;
  end
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      if (!oe_n_i[i]) begin
        level_o[i] = pad_i[i];
      end else if (ext_en_i[i]) begin
        level_o[i] = ext_i[i];
      end else if (pullup_i[i]) begin
        level_o[i] = 1'b1;
      end else begin
        level_o[i] = float_r[i];
      end
    end
  end
endmodule
`default_nettype wire

// ===== gpio_pin_bank.sv
`timescale 1ns/100ps
`default_nettype none

`include "gpio_port_regs.svh"

module gpio_pin_bank #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] latch_i, // Output latch
  input wire logic [WIDTH-1:0] dir_i, // Direction, 1 = input
  input wire logic [WIDTH-1:0] analog_i, // Analog select
  input wire logic [WIDTH-1:0] pullup_i, // Individual pull-up enables
  input wire logic [WIDTH-1:0] od_i, // Open-drain enables
  input wire logic pullup_dis_i, // Global pull-up disable
  input wire logic [WIDTH-1:0] pin_sync_i, // Synchronised pin levels
  output logic [WIDTH-1:0] pad_o_o, // Pad output value
  output logic [WIDTH-1:0] pad_oe_n_o, // Pad drive enable, low drives
  output logic [WIDTH-1:0] pad_pullup_o, // Effective pull-up
  output logic [WIDTH-1:0] analog_conn_o, // Analog input connected
  output logic [WIDTH-1:0] dig_in_o // Digital read value
);

  // ---------------------------------------------------------------
  // Per-pin drive and read logic
  // ---------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      // Open-drain drives only a low level
      pad_o_o[i] = latch_i[i] & ~od_i[i]; // R12 R17 R7
      pad_oe_n_o[i] = dir_i[i] | (od_i[i] & latch_i[i]); // R2 R4 R12 R7
      pad_pullup_o[i] = pullup_i[i] & ~pullup_dis_i & dir_i[i]; // R21 R10 R11
      analog_conn_o[i] = analog_i[i]; // R18
      dig_in_o[i] = pin_sync_i[i] & ~analog_i[i]; // R5 R6
    end
  end

endmodule

`default_nettype wire

// ===== gpio_port.sv
// How it works
// (R1) Data register reads live pins 7..4; writes go to the output latch.
// (R2) Direction 1 tri-states the driver, 0 drives the latch; resets to 1.
// (R3) Data writes sample pins, merge written bits, store into the latch.
// (R4) Direction keeps control of drivers even on analog pins.
// (R5) Analog-selected pins read 0 on digital reads.
// (R6) Only analog bits 5..4 exist on port B; 1 disables digital input.
// (R7) Analog select leaves the digital output path untouched.
// (R8) Analog select bits reset to 1 on every reset.
// (R9) Pull-up bits 7..4 enable pull-ups; reset to 1.
// (R10) Global pull-up disable bit turns every individual pull-up off.
// (R11) Pull-up is forced off while the pin is an output.
// (R12) Open-drain bit 1 sinks only, 0 push-pull; reset 0.
// (R13) Slew bit 1 limits slew, 0 full rate; port B resets to 1.
// (R14) Threshold bit 1 Schmitt, 0 TTL; port B resets to 0.
// (R15) Software changes thresholds only with peripherals disabled.
// (R16) Port B bits 3..0 ignore writes and read as 0.
// (R17) After reset each pin is an input with its driver tri-stated.
// (R18) Analog inputs connect in analog mode; digital outputs still drive.
// (R19) Port C is 6 or 8 bits wide, registers sized to match.
// (R20) Software keeps analog pins as inputs to avoid overdrive.
// (R21) Pull-up active = own enable, global clear, pin is input.
//
// Chosen here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none

`include "gpio_port_regs.svh"

module gpio_port #(
  parameter int C_WIDTH = 8
) (
  input wire logic clk_i, // System clock, 10 MHz
  input wire logic rstn_i, // Async reset, active low
  input wire logic [`ADDR_W-1:0] avs_address, // Word address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte enables
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall, high until answer
  output logic avs_response_err, // Unmapped access flag
  input wire logic [3:0] pin_b_i, // Port B pin levels
  output logic [3:0] pin_b_o, // Port B pad output
  output logic [3:0] pin_b_oe_n_o, // Port B drive, low drives
  output logic [3:0] pullup_b_o, // Port B pull-up on
  output logic [3:0] slew_b_o, // Port B slew limited
  output logic [3:0] schmitt_b_o, // Port B Schmitt select
  output logic [3:0] analog_b_o, // Port B analog connected
  input wire logic [C_WIDTH-1:0] pin_c_i, // Port C pin levels
  output logic [C_WIDTH-1:0] pin_c_o, // Port C pad output
  output logic [C_WIDTH-1:0] pin_c_oe_n_o, // Port C drive, low drives
  output logic [C_WIDTH-1:0] pullup_c_o, // Port C pull-up on
  output logic [C_WIDTH-1:0] slew_c_o, // Port C slew limited
  output logic [C_WIDTH-1:0] schmitt_c_o, // Port C Schmitt select
  output logic [C_WIDTH-1:0] analog_c_o // Port C analog connected
);

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  if (C_WIDTH != 6 && C_WIDTH != 8) begin : g_bad_width
    $error("C_WIDTH must be 6 or 8"); // R19
  end

  // ---------------------------------------------------------------
  // Registers (8-bit views; unimplemented bits held at zero)
  // ---------------------------------------------------------------
  localparam logic [7:0] C_MASK = `C_ALL_ONES >> (8 - C_WIDTH); // R19

  logic [7:0] dir_b_r, lat_b_r, ana_b_r, wpu_b_r, od_b_r, slr_b_r, inl_b_r;
  logic [7:0] dir_c_r, lat_c_r, ana_c_r, wpu_c_r, od_c_r, slr_c_r, inl_c_r;
  logic [7:0] opt_r;
  gpio_port_pkg::bus_state_t state_r;
  logic [31:0] rdata_r;
  logic err_r;

  logic [3:0] sync_b;
  logic [C_WIDTH-1:0] sync_c;
  logic [3:0] din_b;
  logic [C_WIDTH-1:0] din_c;
  logic [7:0] pins_b, pins_c;
  logic [7:0] wbyte;
  logic take;
  logic wr_hit;
  logic mapped;
  logic pullup_dis;

  assign pullup_dis = opt_r[`OPT_PULLUP_DIS_BIT];

  // ---------------------------------------------------------------
  // Pin input synchronisers
  // ---------------------------------------------------------------
  gpio_sync2 #(.WIDTH(4)) u_sync_b (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i(pin_b_i),
    .q_o(sync_b)
  );

  gpio_sync2 #(.WIDTH(C_WIDTH)) u_sync_c (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i(pin_c_i),
    .q_o(sync_c)
  );

  // ---------------------------------------------------------------
  // Pin banks
  // ---------------------------------------------------------------
  gpio_pin_bank #(.WIDTH(4)) u_bank_b (
    .latch_i(lat_b_r[7:4]),
    .dir_i(dir_b_r[7:4]),
    .analog_i(ana_b_r[7:4]),
    .pullup_i(wpu_b_r[7:4]),
    .od_i(od_b_r[7:4]),
    .pullup_dis_i(pullup_dis),
    .pin_sync_i(sync_b),
    .pad_o_o(pin_b_o),
    .pad_oe_n_o(pin_b_oe_n_o),
    .pad_pullup_o(pullup_b_o),
    .analog_conn_o(analog_b_o),
    .dig_in_o(din_b)
  );

  gpio_pin_bank #(.WIDTH(C_WIDTH)) u_bank_c (
    .latch_i(lat_c_r[C_WIDTH-1:0]),
    .dir_i(dir_c_r[C_WIDTH-1:0]),
    .analog_i(ana_c_r[C_WIDTH-1:0]),
    .pullup_i(wpu_c_r[C_WIDTH-1:0]),
    .od_i(od_c_r[C_WIDTH-1:0]),
    .pullup_dis_i(pullup_dis),
    .pin_sync_i(sync_c),
    .pad_o_o(pin_c_o),
    .pad_oe_n_o(pin_c_oe_n_o),
    .pad_pullup_o(pullup_c_o),
    .analog_conn_o(analog_c_o),
    .dig_in_o(din_c)
  );

  assign slew_b_o = slr_b_r[7:4]; // R13
  assign schmitt_b_o = inl_b_r[7:4]; // R14
  assign slew_c_o = slr_c_r[C_WIDTH-1:0]; // R13
  assign schmitt_c_o = inl_c_r[C_WIDTH-1:0]; // R14

  assign pins_b = {din_b, 4'h0}; // R1 R16
  assign pins_c = 8'(din_c);

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  assign take = (state_r == gpio_port_pkg::BUS_IDLE) &
                (avs_read | avs_write);
  assign wr_hit = take & avs_write & avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];
  assign mapped = (avs_address <= `A_OPTION);

  assign avs_waitrequest = (state_r != gpio_port_pkg::BUS_ANSWER);
  assign avs_readdata = rdata_r;
  assign avs_response_err = err_r;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= gpio_port_pkg::BUS_IDLE;
    end else begin
      unique case (state_r)
        gpio_port_pkg::BUS_IDLE: begin
          if (avs_read | avs_write) begin
            state_r <= gpio_port_pkg::BUS_ANSWER;
          end
        end
        gpio_port_pkg::BUS_ANSWER: begin
          state_r <= gpio_port_pkg::BUS_IDLE;
        end
        default: begin
          state_r <= gpio_port_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_r <= '0;
      err_r <= 1'b0;
    end else if (take) begin
      err_r <= ~mapped;
      unique case (avs_address)
        `A_PIN_LEVEL_DATA_B: rdata_r <= {24'h0, pins_b}; // R1 R5
        `A_DIRECTION_CONTROL_B: rdata_r <= {24'h0, dir_b_r};
        `A_OUTPUT_LATCH_B: rdata_r <= {24'h0, lat_b_r};
        `A_ANALOG_SELECT_B: rdata_r <= {24'h0, ana_b_r};
        `A_PULLUP_ENABLE_B: rdata_r <= {24'h0, wpu_b_r};
        `A_OPEN_DRAIN_ENABLE_B: rdata_r <= {24'h0, od_b_r};
        `A_SLEW_LIMIT_ENABLE_B: rdata_r <= {24'h0, slr_b_r};
        `A_INPUT_THRESHOLD_SELECT_B: rdata_r <= {24'h0, inl_b_r};
        `A_PIN_LEVEL_DATA_C: rdata_r <= {24'h0, pins_c}; // R1 R5
        `A_DIRECTION_CONTROL_C: rdata_r <= {24'h0, dir_c_r};
        `A_OUTPUT_LATCH_C: rdata_r <= {24'h0, lat_c_r};
        `A_ANALOG_SELECT_C: rdata_r <= {24'h0, ana_c_r};
        `A_PULLUP_ENABLE_C: rdata_r <= {24'h0, wpu_c_r};
        `A_OPEN_DRAIN_ENABLE_C: rdata_r <= {24'h0, od_c_r};
        `A_SLEW_LIMIT_ENABLE_C: rdata_r <= {24'h0, slr_c_r};
        `A_INPUT_THRESHOLD_SELECT_C: rdata_r <= {24'h0, inl_c_r};
        `A_OPTION: rdata_r <= {24'h0, opt_r};
        default: rdata_r <= '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Port B registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dir_b_r <= `B_DIR_RST; // R2
    end else if (wr_hit && avs_address == `A_DIRECTION_CONTROL_B) begin
      dir_b_r <= wbyte & `B_IMPL_MASK; // R16
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lat_b_r <= '0;
    end else if (wr_hit && avs_address == `A_PIN_LEVEL_DATA_B) begin
      // Written bits 7..4 land; pins sampled for merge
      lat_b_r <= ((pins_b & ~`B_IMPL_MASK) | wbyte) & `B_IMPL_MASK; // R3
    end else if (wr_hit && avs_address == `A_OUTPUT_LATCH_B) begin
      lat_b_r <= wbyte & `B_IMPL_MASK; // R1
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ana_b_r <= `B_ANALOG_RST; // R8
    end else if (wr_hit && avs_address == `A_ANALOG_SELECT_B) begin
      ana_b_r <= wbyte & `B_ANALOG_MASK; // R6
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wpu_b_r <= `B_PULLUP_RST; // R9
    end else if (wr_hit && avs_address == `A_PULLUP_ENABLE_B) begin
      wpu_b_r <= wbyte & `B_IMPL_MASK;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      od_b_r <= `B_OD_RST; // R12
    end else if (wr_hit && avs_address == `A_OPEN_DRAIN_ENABLE_B) begin
      od_b_r <= wbyte & `B_IMPL_MASK;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      slr_b_r <= `B_SLEW_RST; // R13
    end else if (wr_hit && avs_address == `A_SLEW_LIMIT_ENABLE_B) begin
      slr_b_r <= wbyte & `B_IMPL_MASK;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      inl_b_r <= `B_THRESH_RST; // R14
    end else if (wr_hit && avs_address == `A_INPUT_THRESHOLD_SELECT_B) begin
      inl_b_r <= wbyte & `B_IMPL_MASK;
    end
  end

  // ---------------------------------------------------------------
  // Port C registers and option
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dir_c_r <= C_MASK;
    end else if (wr_hit && avs_address == `A_DIRECTION_CONTROL_C) begin
      dir_c_r <= wbyte & C_MASK; // R19
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lat_c_r <= '0;
    end else if (wr_hit && avs_address == `A_PIN_LEVEL_DATA_C) begin
      // Whole byte is written, so the pin merge leaves nothing over
      lat_c_r <= wbyte & C_MASK; // R3
    end else if (wr_hit && avs_address == `A_OUTPUT_LATCH_C) begin
      lat_c_r <= wbyte & C_MASK;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ana_c_r <= C_MASK; // R8
    end else if (wr_hit && avs_address == `A_ANALOG_SELECT_C) begin
      ana_c_r <= wbyte & C_MASK;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wpu_c_r <= C_MASK;
    end else if (wr_hit && avs_address == `A_PULLUP_ENABLE_C) begin
      wpu_c_r <= wbyte & C_MASK;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      od_c_r <= `C_ZERO;
    end else if (wr_hit && avs_address == `A_OPEN_DRAIN_ENABLE_C) begin
      od_c_r <= wbyte & C_MASK;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      slr_c_r <= C_MASK;
    end else if (wr_hit && avs_address == `A_SLEW_LIMIT_ENABLE_C) begin
      slr_c_r <= wbyte & C_MASK;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      inl_c_r <= C_MASK;
    end else if (wr_hit && avs_address == `A_INPUT_THRESHOLD_SELECT_C) begin
      inl_c_r <= wbyte & C_MASK;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      opt_r <= `OPT_RST;
    end else if (wr_hit && avs_address == `A_OPTION) begin
      opt_r <= wbyte; // R10
    end
  end

endmodule

`default_nettype wire

// ===== gpio_port_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "gpio_port_regs.svh"
module gpio_port_bench;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, avs_response_err;
  logic [3:0] pin_b_i, pin_b_o, pin_b_oe_n_o, pullup_b_o;
  logic [3:0] slew_b_o, schmitt_b_o, analog_b_o;
  logic [7:0] pin_c_i, pin_c_o, pin_c_oe_n_o, pullup_c_o;
  logic [7:0] slew_c_o, schmitt_c_o, analog_c_o;
  logic [3:0] ext_en_b = 4'h0, ext_b = 4'h0;
  logic [7:0] ext_en_c = 8'h0, ext_c = 8'h0, d;
  logic [31:0] lfsr = 32'h98b89ee8;
  logic [32:0] q[$];
  int n_errors = 0, comparisons = 0, cyc = 0;
  logic [7:0] rv [17] = '{8'hc0, 8'hf0, 8'h00, 8'h30, 8'hf0, 8'h00,
    8'hf0, 8'h00, 8'h00, 8'hff, 8'h00, 8'hff, 8'hff, 8'h00, 8'hff,
    8'hff, 8'h00};
  gpio_port dut (.*);
  gpio_pad_model #(.WIDTH(4)) pads_b (.clk_i(clk_i), .pad_i(pin_b_o),
    .oe_n_i(pin_b_oe_n_o), .pullup_i(pullup_b_o), .ext_en_i(ext_en_b),
    .ext_i(ext_b), .level_o(pin_b_i));
  gpio_pad_model #(.WIDTH(8)) pads_c (.clk_i(clk_i), .pad_i(pin_c_o),
    .oe_n_i(pin_c_oe_n_o), .pullup_i(pullup_c_o), .ext_en_i(ext_en_c),
    .ext_i(ext_c), .level_o(pin_c_i));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string nm, input logic [32:0] seen,
                       input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task final_report;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ---------------------------------------------
  // Bus master: hold the request until waitrequest is sampled low
  // ---------------------------------------------
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [7:0] v);
    repeat (2) @(posedge clk_i);
    avs_address <= a;
    avs_writedata <= {24'h0, v};
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge clk_i); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [32:0] e);
    q.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask
  task automatic do_reset;
    rstn_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
  endtask
  // ---------------------------------------------
  // Read monitor and timeout
  // ---------------------------------------------
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 20000) begin
      n_errors++;
      final_report();
    end
    if (rstn_i && avs_read && avs_waitrequest === 1'b0) begin
      check("readdata", {avs_response_err, avs_readdata}, q.pop_front());
    end
  end
  initial begin
    do_reset();
    for (int i = 0; i <= 16; i++) begin
      rd(i[4:0], {25'h0, rv[i]});
    end
    rd(5'h11, 33'h1_0000_0000);
    for (int i = 1; i <= 16; i++) begin
      if (i == 8) continue;
      lfsr = nxt(lfsr);
      bus(1'b1, i[4:0], lfsr[7:0]);
      rd(i[4:0], {25'h0, lfsr[7:0] & (i == 3 ? 8'h30 : i < 8 ? 8'hf0 :
        8'hff)});
    end
    lfsr = nxt(lfsr);
    d = lfsr[7:0];
    bus(1'b1, 5'h01, 8'h00);
    bus(1'b1, 5'h03, 8'h00);
    bus(1'b1, 5'h05, 8'h00);
    bus(1'b1, 5'h00, d);
    rd(5'h02, {25'h0, d & 8'hf0});
    rd(5'h00, {25'h0, d & 8'hf0});
    bus(1'b1, 5'h03, 8'hff);
    @(negedge clk_i);
    check("pin_b_o", pin_b_o, d[7:4]);
    check("pin_b_oe_n_o", pin_b_oe_n_o, 4'h0);
    check("analog_b_o", analog_b_o, 4'h3);
    rd(5'h00, {25'h0, d & 8'hc0});
    bus(1'b1, 5'h05, 8'hf0);
    @(negedge clk_i);
    check("od pin_b_o", pin_b_o, 4'h0);
    check("od pin_b_oe_n_o", pin_b_oe_n_o, d[7:4]);
    bus(1'b1, 5'h01, 8'hf0);
    bus(1'b1, 5'h04, 8'h50);
    bus(1'b1, 5'h10, 8'h00);
    @(negedge clk_i);
    check("pullup_b_o", pullup_b_o, 4'h5);
    bus(1'b1, 5'h10, 8'h80);
    @(negedge clk_i);
    check("gdis pullup_b_o", pullup_b_o, 4'h0);
    bus(1'b1, 5'h10, 8'h00);
    lfsr = nxt(lfsr);
    ext_en_b <= 4'hf;
    ext_b <= lfsr[3:0];
    ext_en_c <= 8'hff;
    ext_c <= lfsr[15:8];
    bus(1'b1, 5'h03, 8'h00);
    bus(1'b1, 5'h09, 8'hff);
    bus(1'b1, 5'h0b, 8'h00);
    rd(5'h00, {25'h0, lfsr[3:0], 4'h0});
    rd(5'h08, {25'h0, lfsr[15:8]});
    bus(1'b1, 5'h06, 8'h30);
    bus(1'b1, 5'h07, 8'hc0);
    @(negedge clk_i);
    check("slew_b_o", slew_b_o, 4'h3);
    check("schmitt_b_o", schmitt_b_o, 4'hc);
    do_reset();
    rd(5'h03, {25'h0, 8'h30});
    rd(5'h0b, {25'h0, 8'hff});
    @(negedge clk_i);
    check("slew_c_o", slew_c_o, 8'hff);
    check("schmitt_c_o", schmitt_c_o, 8'hff);
    check("analog_c_o", analog_c_o, 8'hff);
    check("pullup_c_o", pullup_c_o, 8'hff);
    check("pin_c_oe_n_o", pin_c_oe_n_o, 8'hff);
    check("pin_c_o", pin_c_o, 8'h00);
    avs_byteenable <= 4'he;
    bus(1'b1, 5'h01, 8'h00);
    avs_byteenable <= 4'hf;
    rd(5'h01, {25'h0, 8'hf0});
    final_report();
  end
endmodule
bind gpio_port gpio_port_checker #(.C_WIDTH(C_WIDTH)) chk (.*);
`default_nettype wire

// ===== gpio_port_checker.sv
`timescale 1ns/100ps
`default_nettype none
`include "gpio_port_regs.svh"
module gpio_port_checker #(
  parameter int C_WIDTH = 8
) (
  input wire logic clk_i, // clock
  input wire logic rstn_i, // reset
  input wire logic [`ADDR_W-1:0] avs_address, // address
  input wire logic avs_read, // read
  input wire logic avs_write, // write
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte enables
  input wire logic [31:0] avs_readdata, // read data
  input wire logic avs_waitrequest, // stall
  input wire logic [3:0] pin_b_oe_n_o, // B drive
  input wire logic [3:0] pullup_b_o, // B pull-up
  input wire logic [3:0] slew_b_o, // B slew
  input wire logic [3:0] schmitt_b_o, // B threshold
  input wire logic [3:0] analog_b_o, // B analog
  input wire logic [C_WIDTH-1:0] pin_c_oe_n_o, // C drive
  input wire logic [C_WIDTH-1:0] pullup_c_o // C pull-up
);
  // ---------------------------------------------
  // Global pull-up disable, tracked at the take edge
  // ---------------------------------------------
  logic gdis_r;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gdis_r <= 1'b0;
    end else if (avs_write && avs_waitrequest && avs_byteenable[0]
                 && avs_address == `A_OPTION) begin
      gdis_r <= avs_writedata[`OPT_PULLUP_DIS_BIT];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // ---------------------------------------------
  // Assertions
  // ---------------------------------------------
  wait_one_a: assert property (
    !avs_waitrequest |=> avs_waitrequest) else $error("long answer");
  take_ans_a: assert property (
    $rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("answer late");
  rd_stable_a: assert property (
    avs_waitrequest |-> $stable(avs_readdata)) else $error("data moved");
  rd_upper_a: assert property (
    !avs_waitrequest && avs_read && avs_address < 5'h08
    |-> avs_readdata[31:8] == 24'h0 && avs_readdata[3:0] == 4'h0)
    else $error("unimplemented bits set");
  rd_analog_a: assert property (
    !avs_waitrequest && avs_read && avs_address == `A_PIN_LEVEL_DATA_B
    |-> (avs_readdata[5:4] & analog_b_o[1:0]) == 2'b00)
    else $error("analog pin read 1");
  ana_impl_a: assert property (
    analog_b_o[3:2] == 2'b00) else $error("analog on pin 7 or 6");
  pu_out_b_a: assert property (
    (pullup_b_o & ~pin_b_oe_n_o) == 4'h0) else $error("B pull-up on out");
  pu_out_c_a: assert property (
    (pullup_c_o & ~pin_c_oe_n_o) == '0) else $error("C pull-up on out");
  pu_global_a: assert property (
    gdis_r |-> pullup_b_o == 4'h0 && pullup_c_o == '0)
    else $error("pull-up despite global disable");
  rst_vals_a: assert property (
    $rose(rstn_i) |-> pin_b_oe_n_o == 4'hf && analog_b_o == 4'h3
    && pullup_b_o == 4'hf && slew_b_o == 4'hf && schmitt_b_o == 4'h0)
    else $error("bad reset state");
endmodule
`default_nettype wire

// ===== gpio_port_pkg.sv
package gpio_port_pkg;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ANSWER = 2'b10
  } bus_state_t;

endpackage

// ===== gpio_port_regs.svh
`ifndef GPIO_PORT_REGS_SVH
`define GPIO_PORT_REGS_SVH

// ---------------------------------------------------------------
// Register word addresses (Avalon word address, one 32-bit word each)
// ---------------------------------------------------------------
`define ADDR_W 5
`define A_PIN_LEVEL_DATA_B 5'h00
`define A_DIRECTION_CONTROL_B 5'h01
`define A_OUTPUT_LATCH_B 5'h02
`define A_ANALOG_SELECT_B 5'h03
`define A_PULLUP_ENABLE_B 5'h04
`define A_OPEN_DRAIN_ENABLE_B 5'h05
`define A_SLEW_LIMIT_ENABLE_B 5'h06
`define A_INPUT_THRESHOLD_SELECT_B 5'h07
`define A_PIN_LEVEL_DATA_C 5'h08
`define A_DIRECTION_CONTROL_C 5'h09
`define A_OUTPUT_LATCH_C 5'h0a
`define A_ANALOG_SELECT_C 5'h0b
`define A_PULLUP_ENABLE_C 5'h0c
`define A_OPEN_DRAIN_ENABLE_C 5'h0d
`define A_SLEW_LIMIT_ENABLE_C 5'h0e
`define A_INPUT_THRESHOLD_SELECT_C 5'h0f
`define A_OPTION 5'h10

// ---------------------------------------------------------------
// Field masks and reset values
// ---------------------------------------------------------------
`define B_IMPL_MASK 8'hf0
`define B_ANALOG_MASK 8'h30
`define B_DIR_RST 8'hf0
`define B_ANALOG_RST 8'h30
`define B_PULLUP_RST 8'hf0
`define B_OD_RST 8'h00
`define B_SLEW_RST 8'hf0
`define B_THRESH_RST 8'h00
`define C_ALL_ONES 8'hff
`define C_ZERO 8'h00
`define OPT_PULLUP_DIS_BIT 7
`define OPT_RST 8'h00

`endif

// ===== gpio_sync2.sv
`timescale 1ns/100ps
`default_nettype none

module gpio_sync2 #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i, // System clock
  input wire logic rstn_i, // Async reset, active low
  input wire logic [WIDTH-1:0] d_i, // Asynchronous pin levels
  output logic [WIDTH-1:0] q_o // Synchronised levels
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end

endmodule

`default_nettype wire
